// ### design/tws_pkg.sv
// Overview of operation
// - Host changes data on shift-clock rise; device samples data on shift-clock fall.
// - On reads the device drives bits on rises; host samples on falls.
// - First octet is a seven-bit address, MSB first, then the direction bit.
// - Direction bit one requests a read, zero requests a write.
// - Registers are eight bits; every octet is shifted whole, MSB first.
// - Written values reach the addressed registers only when select falls.
// - Main and reference dividers are twelve bits, swallow six, split over addresses.
// - Divider set zero serves transmitted zeros, set one transmitted ones.
// - Receive oscillator frequency always comes from divider set zero.
// - Five-bit crystal trim: zero connects no capacitors, all ones connects all.
// - Crystal oscillator starts first; other circuits enable after it settles.
// - With lock indicator enabled, the lock pin is high while the loop is locked.
// - Host loads transmit dividers before the amplifier; lock may read unlocked meanwhile.
// - Select is active high; rising opens and falling closes a transaction.
// - Each further write octet goes to the next higher address.
// - First shift-clock rise after the address octet of a read turns data to output.
// - Reads never change register contents.
package tws_pkg;

  // Register map.
  localparam int unsigned NUM_REGS = 22;
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] ADR_MODE = 7'h00;
  localparam logic [6:0] ADR_DET_FILT = 7'h01;
  localparam logic [6:0] ADR_OSC_BIAS_BAND = 7'h03;
  localparam logic [6:0] ADR_XTAL_TRIM = 7'h09;
  localparam logic [6:0] ADR_SWALLOW0 = 7'h0a;
  localparam logic [6:0] ADR_MAIN0_HI = 7'h0b;
  localparam logic [6:0] ADR_MAIN0_LO = 7'h0c;
  localparam logic [6:0] ADR_REF0_HI = 7'h0d;
  localparam logic [6:0] ADR_REF0_LO = 7'h0e;
  localparam logic [6:0] ADR_SWALLOW1 = 7'h0f;
  localparam logic [6:0] ADR_MAIN1_HI = 7'h10;
  localparam logic [6:0] ADR_MAIN1_LO = 7'h11;
  localparam logic [6:0] ADR_REF1_HI = 7'h12;
  localparam logic [6:0] ADR_REF1_LO = 7'h13;

  // Field positions.
  localparam int unsigned MODE_LSB = 1;
  localparam int unsigned LOCK_EN_BIT = 2;
  localparam int unsigned BAND_LSB = 0;
  localparam int unsigned BIAS_LSB = 2;
  localparam int unsigned TRIM_LSB = 0;
  localparam int unsigned HI_NIBBLE_W = 4;

  // Operating modes held in the mode register.
  localparam logic [1:0] MODE_RECEIVE = 2'h2;
  localparam logic [1:0] MODE_TRANSMIT = 2'h3;

  // Reset values: trim defaults to 13 with its fixed upper pattern.
  localparam logic [7:0] RST_XTAL_TRIM = 8'h2d;
  localparam logic [7:0] RST_OTHER = 8'h00;

  // Crystal start-up time.
  localparam int unsigned XCO_SETTLE_US = 750;
  localparam int unsigned CLK_KHZ = 25_000;
  localparam int unsigned XCO_SETTLE_CYC = XCO_SETTLE_US * CLK_KHZ / 1000;

endpackage

// ### design/tws_cfg_bank.sv
`timescale 1ns/10ps
// Active configuration bank with per-entry load and a registered read port.
module tws_cfg_bank #(
  parameter int unsigned DEPTH = tws_pkg::NUM_REGS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Parallel load from the holding store.
  input wire logic [DEPTH-1:0] load_en,
  input wire logic [DEPTH*8-1:0] load_data,
  // Read port.
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data,
  // Whole bank for the decode logic.
  output logic [DEPTH*8-1:0] bank
);

  // The read address is seven bits wide, so no more than 128 entries can be reached.
  if (DEPTH < 1 || DEPTH > 128)
  begin : g_bad_depth
    $error("Bank depth out of range.");
  end

  // Each entry loads only on its own strobe, so unwritten entries keep their value.
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_ent
      localparam logic [7:0] RST_VAL = (gi == int'(tws_pkg::ADR_XTAL_TRIM)) ?
        tws_pkg::RST_XTAL_TRIM : tws_pkg::RST_OTHER;
      always_ff @(posedge clk)
      begin
        if (!rst_b)
          bank[gi*8 +: 8] <= RST_VAL;
        else if (load_en[gi])
          bank[gi*8 +: 8] <= load_data[gi*8 +: 8];
      end
    end
  endgenerate

  // Out-of-range reads return zero.
  wire rd_in_range = (int'(rd_addr) < DEPTH);
  wire [7:0] rd_sel = rd_in_range ? bank[int'(rd_addr)*8 +: 8] : 8'h00;

  // Read data leaves from a register.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rd_data <= 8'h00;
    else
      rd_data <= rd_sel;
  end

endmodule

// ### design/tws_config_port.sv
`timescale 1ns/10ps
// Three-wire configuration port and synthesizer control registers.
module tws_config_port #(
  parameter int unsigned XCO_SETTLE_CYCLES = tws_pkg::XCO_SETTLE_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Serial port pins.
  input wire logic sel,
  input wire logic sclk,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_b,
  // Radio status inputs.
  input wire logic pll_locked,
  input wire logic tx_symbol,
  // Lock indicator pin.
  output logic lock_indicator_pin,
  // Power sequencing.
  output logic xco_enable,
  output logic circuits_enable,
  // Active synthesizer and oscillator settings.
  output logic [11:0] syn_main_div,
  output logic [11:0] syn_ref_div,
  output logic [5:0] syn_swallow_div,
  output logic [4:0] crystal_trim_bits,
  output logic [2:0] oscillator_bias_bits,
  output logic [1:0] oscillator_band_bits
);

  localparam int unsigned NR = tws_pkg::NUM_REGS;

  // The start-up counter is twenty bits wide, which bounds the settle count.
  if (XCO_SETTLE_CYCLES < 1 || XCO_SETTLE_CYCLES > 1_000_000)
  begin : g_bad_settle
    $error("Settle count out of range.");
  end

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_READ = 4'b1000
  } tws_state_t;

  // Pin synchronisers and edge history.
  logic sclk_m_ff, sclk_s_ff, sclk_d_ff;
  logic sel_m_ff, sel_s_ff, sel_d_ff;
  logic sdio_m_ff, sdio_s_ff;
  logic lock_m_ff, lock_s_ff;
  logic sym_m_ff, sym_s_ff;

  // Port state.
  tws_state_t state_ff, nxt_state;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [6:0] addr_ff;
  logic [NR*8-1:0] hold_ff;
  logic [NR-1:0] pend_ff;
  logic [19:0] settle_cnt_ff;
  logic settled_ff;

  // Bank wiring.
  logic [NR*8-1:0] bank;
  logic [7:0] rd_data;
  wire [NR-1:0] load_en;

  // Every synchroniser first stage feeds only its second stage. Two flops per pin bound the
  // metastability window; the third flop on select and shift clock only keeps the previous
  // level, and it resets to the idle low level so no false edge follows reset.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sclk_m_ff <= 1'b0;
      sclk_s_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      sel_m_ff <= 1'b0;
      sel_s_ff <= 1'b0;
      sel_d_ff <= 1'b0;
      sdio_m_ff <= 1'b0;
      sdio_s_ff <= 1'b0;
      lock_m_ff <= 1'b0;
      lock_s_ff <= 1'b0;
      sym_m_ff <= 1'b0;
      sym_s_ff <= 1'b0;
    end
    else
    begin
      sclk_m_ff <= sclk;
      sclk_s_ff <= sclk_m_ff;
      sclk_d_ff <= sclk_s_ff;
      sel_m_ff <= sel;
      sel_s_ff <= sel_m_ff;
      sel_d_ff <= sel_s_ff;
      sdio_m_ff <= sdio_in;
      sdio_s_ff <= sdio_m_ff;
      lock_m_ff <= pll_locked;
      lock_s_ff <= lock_m_ff;
      sym_m_ff <= tx_symbol;
      sym_s_ff <= sym_m_ff;
    end
  end

  // Edge events on the synchronised pins.
  // Edges are found one flop late, which costs a clock of latency but never misses one.
  wire sclk_rise = sclk_s_ff & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s_ff & sclk_d_ff;
  wire sel_rise = sel_s_ff & ~sel_d_ff;
  wire sel_fall = ~sel_s_ff & sel_d_ff;

  // Octet bookkeeping; data and clock share the same synchroniser depth, so they stay aligned.
  wire octet_done = sclk_fall & (bit_cnt_ff == 3'h7);
  wire [7:0] shift_in = {shift_ff[6:0], sdio_s_ff};
  wire dir_read = shift_in[0];
  wire addr_valid = (int'(addr_ff) < NR);
  wire [6:0] addr_inc = addr_ff + 7'h01;
  wire rd_bit = rd_data[~bit_cnt_ff];
  wire rd_drive = addr_valid ? rd_bit : 1'b0;

  // Transactions only open once the crystal has settled, so early programming is ignored.
  wire open_ok = sel_rise & settled_ff;

  // Transaction sequencing.
  // A select fall closes from any state, so an aborted transfer leaves nothing half done.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (open_ok)
          nxt_state = ST_ADDR;
      end
      ST_ADDR:
      begin
        if (sel_fall)
          nxt_state = ST_IDLE;
        else if (octet_done)
          nxt_state = dir_read ? ST_READ : ST_WRITE;
      end
      ST_WRITE:
      begin
        if (sel_fall)
          nxt_state = ST_IDLE;
      end
      ST_READ:
      begin
        if (sel_fall)
          nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Bit counter restarts on every open and wraps per octet.
  // Restarting in idle is what drops a partial octet at a close.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      bit_cnt_ff <= 3'h0;
    else if (state_ff == ST_IDLE)
      bit_cnt_ff <= 3'h0;
    else if (sclk_fall)
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
  end

  // Incoming bits enter MSB first on falling shift-clock edges.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      shift_ff <= 8'h00;
    else if (sclk_fall && state_ff != ST_IDLE)
      shift_ff <= shift_in;
  end

  // Address is captured from the first octet and steps after each data octet.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      addr_ff <= 7'h00;
    else if (state_ff == ST_ADDR && octet_done)
      addr_ff <= shift_in[7:1];
    else if ((state_ff == ST_WRITE || state_ff == ST_READ) && octet_done)
      addr_ff <= addr_inc;
  end

  // Load strobe for the bank: a write transaction closing.
  wire write_close = sel_fall & (state_ff == ST_WRITE);

  // Holding store: written octets wait here, marked pending, until select drops.
  genvar gi;
  generate
    for (gi = 0; gi < NR; gi++)
    begin : g_hold
      wire hit = (state_ff == ST_WRITE) && octet_done && (int'(addr_ff) == gi);
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          hold_ff[gi*8 +: 8] <= 8'h00;
          pend_ff[gi] <= 1'b0;
        end
        else if (hit)
        begin
          hold_ff[gi*8 +: 8] <= shift_in;
          pend_ff[gi] <= 1'b1;
        end
        else if (state_ff == ST_IDLE)
          pend_ff[gi] <= 1'b0;
      end
      // A hit in the same cycle as a close is not loaded: its pend_ff bit sets a clock after load_en is taken.
      assign load_en[gi] = pend_ff[gi] & write_close;
    end
  endgenerate

  // Reads only look at the bank; nothing in the read path writes it.
  // Read data trail the address by one clock, ample for a shift-clock phase of three.
  tws_cfg_bank #(
    .DEPTH(NR)
  ) u_bank (
    .clk(clk),
    .rst_b(rst_b),
    .load_en(load_en),
    .load_data(hold_ff),
    .rd_addr(addr_ff),
    .rd_data(rd_data),
    .bank(bank)
  );

  // Data pin: turned to output on the first rise of a read, released when select falls.
  // The pin moves about three clocks after the host's rise, settled before the host's fall.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sdio_oe_b <= 1'b1;
      sdio_out <= 1'b0;
    end
    else if (state_ff != ST_READ || sel_fall)
    begin
      sdio_oe_b <= 1'b1;
      sdio_out <= 1'b0;
    end
    else if (sclk_rise)
    begin
      sdio_oe_b <= 1'b0;
      sdio_out <= rd_drive;
    end
  end

  // Crystal runs from reset; the rest waits for the start-up count to expire.
  // A larger trim value lengthens the real start-up, so the count is a parameter.
  // Requests seen before the count expires are ignored, not queued.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      settle_cnt_ff <= 20'h0_0000;
      settled_ff <= 1'b0;
      xco_enable <= 1'b0;
      circuits_enable <= 1'b0;
    end
    else
    begin
      xco_enable <= 1'b1;
      if (!settled_ff)
        settle_cnt_ff <= settle_cnt_ff + 20'h0_0001;
      if (int'(settle_cnt_ff) >= XCO_SETTLE_CYCLES - 1)
        settled_ff <= 1'b1;
      circuits_enable <= settled_ff;
    end
  end

  // Field decode from the active bank.
  // Only the fields below leave the block; the other bits are kept for read-back.
  wire [7:0] r_mode = bank[int'(tws_pkg::ADR_MODE)*8 +: 8];
  wire [7:0] r_det = bank[int'(tws_pkg::ADR_DET_FILT)*8 +: 8];
  wire [7:0] r_osc = bank[int'(tws_pkg::ADR_OSC_BIAS_BAND)*8 +: 8];
  wire [7:0] r_trim = bank[int'(tws_pkg::ADR_XTAL_TRIM)*8 +: 8];
  wire [1:0] mode = r_mode[tws_pkg::MODE_LSB +: 2];
  wire lock_en = r_det[tws_pkg::LOCK_EN_BIT];

  // Divider sets, each split across consecutive addresses.
  // Unused upper bits of the high registers read back but never reach the dividers.
  function automatic logic [11:0] tws_div12(input logic [7:0] hi, input logic [7:0] lo);
    tws_div12 = {hi[tws_pkg::HI_NIBBLE_W-1:0], lo};
  endfunction

  wire [11:0] main0 = tws_div12(bank[int'(tws_pkg::ADR_MAIN0_HI)*8 +: 8],
    bank[int'(tws_pkg::ADR_MAIN0_LO)*8 +: 8]);
  wire [11:0] ref0 = tws_div12(bank[int'(tws_pkg::ADR_REF0_HI)*8 +: 8],
    bank[int'(tws_pkg::ADR_REF0_LO)*8 +: 8]);
  wire [5:0] swal0 = bank[int'(tws_pkg::ADR_SWALLOW0)*8 +: 6];
  wire [11:0] main1 = tws_div12(bank[int'(tws_pkg::ADR_MAIN1_HI)*8 +: 8],
    bank[int'(tws_pkg::ADR_MAIN1_LO)*8 +: 8]);
  wire [11:0] ref1 = tws_div12(bank[int'(tws_pkg::ADR_REF1_HI)*8 +: 8],
    bank[int'(tws_pkg::ADR_REF1_LO)*8 +: 8]);
  wire [5:0] swal1 = bank[int'(tws_pkg::ADR_SWALLOW1)*8 +: 6];

  // Set one only while transmitting a one; receive and idle stay on set zero. The symbol
  // pin is synchronised, so a symbol change reaches the dividers three clocks later.
  wire use_set1 = (mode == tws_pkg::MODE_TRANSMIT) & sym_s_ff;

  // Selection of the active divider set and of the lock pin level.
  wire [11:0] act_main = use_set1 ? main1 : main0;
  wire [11:0] act_ref = use_set1 ? ref1 : ref0;
  wire [5:0] act_swal = use_set1 ? swal1 : swal0;
  // The pin follows the loop even while the amplifier ramps, so it may read unlocked then.
  wire lock_show = lock_en & lock_s_ff;

  // Registered outputs of the active configuration.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      syn_main_div <= 12'h000;
      syn_ref_div <= 12'h000;
      syn_swallow_div <= 6'h00;
      crystal_trim_bits <= tws_pkg::RST_XTAL_TRIM[4:0];
      oscillator_bias_bits <= 3'h0;
      oscillator_band_bits <= 2'h0;
      lock_indicator_pin <= 1'b0;
    end
    else
    begin
      syn_main_div <= act_main;
      syn_ref_div <= act_ref;
      syn_swallow_div <= act_swal;
      crystal_trim_bits <= r_trim[tws_pkg::TRIM_LSB +: 5];
      oscillator_bias_bits <= r_osc[tws_pkg::BIAS_LSB +: 3];
      oscillator_band_bits <= r_osc[tws_pkg::BAND_LSB +: 2];
      lock_indicator_pin <= lock_show;
    end
  end

endmodule

// ### tb/tws_config_port_asserts.sv
`timescale 1ns/10ps
// Pin-level checks; the counter mirrors the start-up wait after reset.
module tws_config_port_asserts #(
  parameter int unsigned XCO_SETTLE_CYCLES = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Watched pins.
  input wire logic sel,
  input wire logic sclk,
  input wire logic sdio_out,
  input wire logic sdio_oe_b,
  input wire logic pll_locked,
  input wire logic lock_indicator_pin,
  input wire logic xco_enable,
  input wire logic circuits_enable,
  input wire logic [4:0] crystal_trim_bits,
  input wire logic [2:0] oscillator_bias_bits
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  int cnt_ff;
  // Saturates so the count never wraps in a long run.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cnt_ff <= 0;
    else if (cnt_ff < XCO_SETTLE_CYCLES + 8)
      cnt_ff <= cnt_ff + 1;
  end
  chk_oe_idle_desel: assert property (!sel [*5] |-> sdio_oe_b)
    else $error("data pin driven while deselected");
  chk_oe_after_rise: assert property ($fell(sdio_oe_b) |-> sel && $past(sclk, 2))
    else $error("data pin turned without a clock rise");
  chk_out_on_rise: assert property (
    $changed(sdio_out) && !sdio_oe_b |-> $past(sclk, 2))
    else $error("read bit moved away from a clock rise");
  chk_out_idle_low: assert property (sdio_oe_b |-> !sdio_out)
    else $error("drive value not low while released");
  chk_trim_on_load: assert property ($changed(crystal_trim_bits) |-> !$past(sel, 2))
    else $error("trim changed while selected");
  chk_bias_hold_sel: assert property (sel |=> $stable(oscillator_bias_bits))
    else $error("bias changed during a transaction");
  chk_lock_low: assert property (!pll_locked [*4] |-> !lock_indicator_pin)
    else $error("lock pin high while unlocked");
  chk_xco_first: assert property (circuits_enable |-> xco_enable)
    else $error("circuits on without oscillator");
  chk_settle_min: assert property (
    $rose(circuits_enable) |-> cnt_ff >= XCO_SETTLE_CYCLES)
    else $error("circuits on before settling");
  chk_settle_due: assert property (
    cnt_ff == XCO_SETTLE_CYCLES + 4 |-> circuits_enable)
    else $error("circuits not on after settling");
  cov_read_drive: cover property ($fell(sdio_oe_b));
  cov_trim_load: cover property ($changed(crystal_trim_bits));
  cov_lock_high: cover property ($rose(lock_indicator_pin));
endmodule

// ### tb/tws_host_model.sv
`timescale 1ns/10ps
// Host of the serial port; sclk stands low outside transactions.
module tws_host_model (
  // Clock.
  input wire logic clk,
  // Device drive of the data pin.
  input wire logic sdio_out,
  input wire logic sdio_oe_b,
  // Pins towards the device.
  output logic sel,
  output logic sclk,
  output logic sdio_in
);
  logic drv, dq, flip;
  logic [7:0] wq[$], rq[$];
  // A floating line toggles so a stale level cannot pass for read data.
  initial
  begin
    sel = 1'b0;
    sclk = 1'b0;
    drv = 1'b1;
    dq = 1'b0;
    flip = 1'b0;
  end
  always @(posedge clk) flip <= ~flip;
  assign sdio_in = !sdio_oe_b ? sdio_out : (drv ? dq : flip);
  // Data moves with the rise; read bits are taken just after the fall.
  task automatic octet(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      sclk <= 1'b1;
      dq <= w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      @(negedge clk) r[i] = sdio_in;
      repeat (4) @(posedge clk);
    end
  endtask
  // One transaction: address octet, then n data octets in or out.
  task automatic xfer(input logic [6:0] a, input logic rd, input int n);
    logic [7:0] r;
    sel <= 1'b1;
    repeat (4) @(posedge clk);
    octet({a, rd}, r);
    drv <= !rd;
    for (int i = 0; i < n; i++)
    begin
      octet(rd ? 8'h00 : wq.pop_front(), r);
      if (rd) rq.push_back(r);
    end
    repeat (4) @(posedge clk);
    sel <= 1'b0;
    drv <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ### tb/tb_tws_config_port.sv
`timescale 1ns/10ps
// Bench: a register-array model is compared with the device pins.
module tb_tws_config_port;
  logic clk, rst_b, sel, sclk, sdio_in, sdio_out, sdio_oe_b, pll_locked, tx_symbol;
  logic lock_indicator_pin, xco_enable, circuits_enable;
  logic [11:0] syn_main_div, syn_ref_div;
  logic [5:0] syn_swallow_div;
  logic [4:0] crystal_trim_bits;
  logic [2:0] oscillator_bias_bits;
  logic [1:0] oscillator_band_bits;
  logic [7:0] mdl [22];
  logic [31:0] seed;
  int error_cnt, cmp_count;
  tws_config_port #(.XCO_SETTLE_CYCLES(16)) tws_config_port_inst (
    .clk(clk), .rst_b(rst_b), .sel(sel), .sclk(sclk), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe_b(sdio_oe_b), .pll_locked(pll_locked),
    .tx_symbol(tx_symbol), .lock_indicator_pin(lock_indicator_pin),
    .xco_enable(xco_enable), .circuits_enable(circuits_enable),
    .syn_main_div(syn_main_div), .syn_ref_div(syn_ref_div),
    .syn_swallow_div(syn_swallow_div), .crystal_trim_bits(crystal_trim_bits),
    .oscillator_bias_bits(oscillator_bias_bits),
    .oscillator_band_bits(oscillator_band_bits)
  );
  tws_host_model tws_host_model_inst (
    .clk(clk), .sdio_out(sdio_out), .sdio_oe_b(sdio_oe_b),
    .sel(sel), .sclk(sclk), .sdio_in(sdio_in)
  );
  // 25 MHz system clock.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr1(input logic [6:0] a, input logic [7:0] v);
    mdl[a] = v;
    tws_host_model_inst.wq.push_back(v);
    tws_host_model_inst.xfer(a, 1'b0, 1);
  endtask
  // Runs one place past the end, where the device reads zero.
  task automatic rd_all;
    tws_host_model_inst.xfer(7'h00, 1'b1, 23);
    for (int i = 0; i < 23; i++)
      cmp(tws_host_model_inst.rq.pop_front(), i < 22 ? mdl[i] : 8'h00);
  endtask
  // Set one serves only a transmitted one; receive always uses set zero.
  task automatic check_outs;
    logic s;
    s = mdl[0][2:1] == tws_pkg::MODE_TRANSMIT && tx_symbol;
    cmp(syn_main_div, s ? {mdl[16][3:0], mdl[17]} : {mdl[11][3:0], mdl[12]});
    cmp(syn_ref_div, s ? {mdl[18][3:0], mdl[19]} : {mdl[13][3:0], mdl[14]});
    cmp(syn_swallow_div, s ? mdl[15][5:0] : mdl[10][5:0]);
    cmp(crystal_trim_bits, mdl[9][4:0]);
    cmp({oscillator_bias_bits, oscillator_band_bits}, mdl[3][4:0]);
    cmp(lock_indicator_pin, mdl[1][2] & pll_locked);
  endtask
  // Main sequence; the first write comes too early and must be ignored.
  initial
  begin
    rst_b = 1'b0;
    pll_locked = 1'b0;
    tx_symbol = 1'b0;
    seed = 32'h0001_6997;
    error_cnt = 0;
    cmp_count = 0;
    foreach (mdl[i]) mdl[i] = (i == 9) ? 8'h2d : 8'h00;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    tws_host_model_inst.wq.push_back(8'h00);
    tws_host_model_inst.xfer(7'h09, 1'b0, 1);
    cmp(circuits_enable, 1'b1);
    cmp(xco_enable, 1'b1);
    cmp(crystal_trim_bits, 5'h0d);
    rd_all();
    // Divider fields stay legal: reference nonzero, swallow from one up to the main divider.
    foreach (mdl[i])
    begin
      mdl[i] = 8'(rnd());
      if (i inside {10, 11, 14, 15, 16, 19})
        mdl[i][0] = 1'b1;
      tws_host_model_inst.wq.push_back(mdl[i]);
    end
    tws_host_model_inst.xfer(7'h00, 1'b0, 22);
    check_outs();
    rd_all();
    wr1(7'h03, 8'hcd);
    check_outs();
    // Receive then transmit mode, each with both symbol levels.
    for (int k = 0; k < 4; k++)
    begin
      wr1(7'h00, k[1] ? 8'h07 : 8'h05);
      tx_symbol <= k[0];
      repeat (6) @(posedge clk);
      check_outs();
    end
    // Lock pin is judged in receive, where the host may trust its transitions.
    wr1(7'h00, 8'h05);
    for (int k = 0; k < 6; k++)
    begin
      wr1(7'h01, 8'(rnd()));
      pll_locked <= seed[9];
      repeat (6) @(posedge clk);
      cmp(lock_indicator_pin, mdl[1][2] & pll_locked);
    end
    end_of_test();
  end
  // Cuts a hang short well after the expected run length.
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule
bind tws_config_port tws_config_port_asserts #(.XCO_SETTLE_CYCLES(XCO_SETTLE_CYCLES)) chk_inst (
  .clk(clk), .rst_b(rst_b), .sel(sel), .sclk(sclk), .sdio_out(sdio_out),
  .sdio_oe_b(sdio_oe_b), .pll_locked(pll_locked),
  .lock_indicator_pin(lock_indicator_pin), .xco_enable(xco_enable),
  .circuits_enable(circuits_enable), .crystal_trim_bits(crystal_trim_bits),
  .oscillator_bias_bits(oscillator_bias_bits)
);
